//--- sim/acc_host_link.sv
// Host side of the external serial link: makes the data clock in bursts and records what comes back.
// Assumes the bench calls burst, after the reset burst, only while the read state is set up and busy is high.
`timescale 1ns/1ps
module acc_host_link #(
    parameter int N = 16
) (
    output logic link_clk,
    input wire logic sout,
    input wire logic frame
);
    logic s_q [N]; // Serial level seen just after each rise
    logic f_q [N]; // Frame level seen just after each rise

    // Clock stands low between bursts, so a busy rise never meets it high
    initial begin
        link_clk = 1'b0;
    end

    // One burst of n pulses at 6 ns; capture 1 ns after each rise once the shift has landed
    task automatic burst(input int n);
        for (int i = 0; i < n; i++) begin
            #3 link_clk = 1'b1;
            #1;
            if (i < N) begin
                s_q[i] = sout;
                f_q[i] = frame;
            end
            #2 link_clk = 1'b0;
        end
    endtask
endmodule

//--- sim/testbench.sv
// Self-checking bench for the convert start and read control: parallel, internal and external serial.
// Assumes the host model drives the link clock and the bench drives every control pin.
`timescale 1ns/1ps
module testbench;
    import acc_pkg::*;
    localparam int CONV = 160; // Conversion count, longer than the default 150
    logic clk;
    logic rstn;
    logic link_clk;
    acc_ctl_t ctl;
    logic [RES_W-1:0] cdata; // Result offered by the core stand-in
    acc_bus_t bus;
    logic busy_n;
    logic cstart, hold, acq_rdy, chan_oe;
    logic [CHAN_W-1:0] chan;
    int n_mismatch = 0;
    int cmp_count = 0;
    int lat, len, npulse, k, nf, nstart;
    logic [RES_W-1:0] sbits;
    logic [RES_W-1:0] xb;
    logic last_sout;

    acc_ctrl #(.CONV_CYCLES(CONV)) dut (.clk(clk), .rstn(rstn), .serial_clock_in(link_clk),
        .ctl_pins(ctl), .conv_data(cdata), .bus(bus), .busy_n(busy_n), .sample_hold(hold),
        .conv_start(cstart), .acq_ready(acq_rdy), .chan_addr(chan), .chan_addr_oe(chan_oe));
    acc_host_link host (.link_clk(link_clk), .sout(bus.dout[PIN_SOUT]), .frame(bus.dout[PIN_FRAME]));

    // 10 MHz system clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Compare and count; case inequality so an unknown never matches
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Step n edges, then settle by the fixed drive delay
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Convert command; measures start latency, busy length and any internal serial stream
    task automatic conv(input logic dup);
        logic prev;
        lat = 0;
        len = 0;
        npulse = 0;
        sbits = '0;
        tick(1);
        ctl.cs_n = 1'b0;
        ctl.rd_conv = 1'b0;
        while (busy_n !== 1'b0 && lat < 8) begin
            tick(1);
            lat++;
        end
        // Start pulses seen; a second one would mean a command was taken while busy
        nstart = (cstart === 1'b1) ? 1 : 0;
        ctl.rd_conv = 1'b1;
        prev = bus.dout[PIN_SCLK];
        while (busy_n !== 1'b1 && len < CONV + 20) begin
            // Optional second command in mid-conversion, which must be ignored
            if (dup && len == 20) ctl.rd_conv = 1'b0;
            if (dup && len == 24) ctl.rd_conv = 1'b1;
            last_sout = bus.dout[PIN_SOUT];
            tick(1);
            len++;
            if (cstart === 1'b1) nstart++;
            if (bus.dout[PIN_SCLK] === 1'b1 && prev === 1'b0) begin
                sbits = {sbits[RES_W-2:0], bus.dout[PIN_SOUT]};
                npulse++;
            end
            prev = bus.dout[PIN_SCLK];
        end
    endtask

    // Single place where the run ends
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #600000;
        n_mismatch++;
        end_of_test();
    end

    // Test sequence
    initial begin
        rstn = 1'b0;
        ctl = CTL_IDLE;
        ctl.parallel_serial_sel = 1'b1;
        cdata = 12'ha5c;
        host.burst(4); // Link logic needs edges to take the reset
        tick(20);
        rstn = 1'b1;
        tick(3);
        // Parallel: select lowered first so read/convert triggers; second command ignored
        ctl.continuous_convert = 1'b1; // Channel steps at each completed conversion
        ctl.cs_n = 1'b0;
        tick(3);
        conv(1'b1);
        chk(nstart, 1, "start pulses");
        chk(lat, 3, "start latency");
        chk(len, CONV, "busy length");
        tick(3);
        chk(bus.oe, 8'hff, "bus enable");
        chk(hold, 1'b0, "sampler tracking");
        chk(acq_rdy, 1'b0, "spacing not yet met");
        chk(chan, 2'h1, "channel step");
        chk(bus.dout, 8'ha5, "upper byte");
        ctl.byte_sel = 1'b1;
        tick(3);
        chk(bus.dout, 8'hc0, "lower nibble");
        ctl.cs_n = 1'b1;
        tick(3);
        chk(bus.oe, 8'h00, "bus float");
        $display("test parallel done");
        // Power-down: command held but no conversion
        ctl.power_down_req = 1'b1;
        tick(3);
        ctl.cs_n = 1'b0;
        ctl.rd_conv = 1'b0;
        tick(10);
        chk(busy_n, 1'b1, "start while powered down");
        chk(chan, 2'h0, "channel reset");
        chk(chan_oe, 1'b1, "channel pins driven");
        ctl.cs_n = 1'b1;
        ctl.rd_conv = 1'b1;
        tick(3);
        ctl.power_down_req = 1'b0;
        ctl.continuous_convert = 1'b0;
        tick(3);
        $display("test power down done");
        // Internal clock serial: previous result out, then chain input level
        ctl.parallel_serial_sel = 1'b0;
        ctl.tag = 1'b1;
        cdata = 12'h3c7;
        tick(3);
        conv(1'b0);
        chk(npulse, 12, "pulse count");
        chk(sbits, 12'ha5c, "serial word");
        chk(last_sout, 1'b1, "level after pulses");
        tick(3);
        chk(bus.oe[PIN_SOUT], 1'b0, "serial out released");
        $display("test internal serial done");
        // External clock serial: frame pulse, word, then chain input
        ctl.external_clock_sel = 1'b1;
        cdata = 12'h6e1;
        tick(3);
        conv(1'b0);
        // Let the frame from the read during conversion land; two toggles with a stopped clock would cancel
        host.burst(6);
        ctl.cs_n = 1'b1;
        tick(3);
        ctl.cs_n = 1'b0;
        tick(5);
        chk(bus.oe[PIN_SOUT], 1'b1, "serial out driven");
        chk(bus.oe[7:5], 3'h0, "upper pins float");
        host.burst(16);
        nf = 0;
        k = 0;
        for (int i = 0; i < 16; i++) begin
            if (host.f_q[i] === 1'b1) begin
                nf++;
                k = i;
            end
        end
        chk(nf, 1, "frame count");
        if (k > 3) k = 3;
        xb = '0;
        for (int i = 0; i < RES_W; i++) xb = {xb[RES_W-2:0], host.s_q[k+i]};
        chk(xb, 12'h6e1, "external word");
        chk(host.s_q[k+12], 1'b1, "chain level");
        $display("test external serial done");
        end_of_test();
    end
endmodule

//--- verilog/acc_ctrl.sv
// Conversion start, busy timing and result read-out (parallel or serial).
// Assumes the conversion core presents its result on conv_data by the end of the count.
`timescale 1ns/1ps
module acc_ctrl import acc_pkg::*; #(
    parameter int CONV_CYCLES = CONV_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic serial_clock_in, // External data clock, the link clock
    input wire acc_ctl_t ctl_pins,
    input wire logic [RES_W-1:0] conv_data, // Result from the conversion core
    output acc_bus_t bus,
    output logic busy_n,
    output logic sample_hold, // High while the sampler holds
    output logic conv_start, // One-cycle start pulse to the core
    output logic acq_ready, // Advised acquisition time has passed
    output logic [CHAN_W-1:0] chan_addr,
    output logic chan_addr_oe
);
    // The serial sequence must finish before busy rises
    if (CONV_CYCLES <= DCLK_DELAY_CYC + NUM_PULSES * DCLK_PERIOD_CYC + 1 || CONV_CYCLES > 65535) begin : g_chk
        $error("acc_ctrl CONV_CYCLES cannot hold the serial sequence");
    end

    // Decrement of a 16-bit counter, saturating at zero
    function automatic logic [15:0] dec16(input logic [15:0] v);
        return (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
    endfunction

    acc_ctl_t sync1_q, sync2_q; // Two-stage pin synchroniser
    logic cmd_low; // Convert command level
    logic rd_state; // Read state level
    logic [2:0] low_cnt_q; // Cycles the command has been low
    logic start; // Accepted convert command
    logic busy_q; // Conversion running
    logic [15:0] conv_cnt_q; // Cycles left in conversion
    logic done; // Last conversion cycle
    logic [RES_W-1:0] result_q; // Output register
    logic [CHAN_W-1:0] chan_q; // Channel in continuous mode
    logic [15:0] acq_cnt_q; // Cycles left until the advised spacing is met
    logic int_mode, ext_mode, par_mode;
    acc_seq_t seq_q; // Internal data clock sequencer
    logic [4:0] seq_cnt_q; // Phase counter
    logic [3:0] bit_cnt_q; // Pulse index
    logic [RES_W-1:0] shreg_q; // Internal mode shift register
    logic sclk_q, sout_q, tag_cap_q;
    logic rd_state_q; // Previous read state, for edges
    logic load_tgl_q, frame_tgl_q; // Events into the link domain
    logic link_sout, link_frame;
    logic [BUS_W-1:0] par_q; // Registered parallel byte
    logic par_en_q; // Parallel bus enable

    // Pins pass two flops before use, except tag, which goes straight to the link chain
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sync1_q <= CTL_IDLE;
            sync2_q <= CTL_IDLE;
        end else begin
            sync1_q <= ctl_pins;
            sync2_q <= sync1_q;
        end
    end

    // Select and read/convert are ORed active-low levels
    assign cmd_low = !sync2_q.cs_n && !sync2_q.rd_conv;
    assign rd_state = !sync2_q.cs_n && sync2_q.rd_conv;
    assign par_mode = sync2_q.parallel_serial_sel;
    assign ext_mode = !par_mode && sync2_q.external_clock_sel;
    assign int_mode = !par_mode && !sync2_q.external_clock_sel;

    // Measure how long the command level has been seen
    always_ff @(posedge clk) begin
        if (!rstn) begin
            low_cnt_q <= 3'h0;
        end else if (!cmd_low) begin
            low_cnt_q <= 3'h0;
        end else if (low_cnt_q != 3'h7) begin
            low_cnt_q <= low_cnt_q + 3'h1;
        end
    end

    // Level triggered start: a command still low at busy rise restarts at once,
    // so the host must lift a control in time or lose acquisition
    assign start = cmd_low && (low_cnt_q >= 3'(CMD_MIN_CYC - 1))
                   && !busy_q && !sync2_q.power_down_req;
    assign done = busy_q && (conv_cnt_q == 16'h0000);

    // Conversion counter drives busy
    always_ff @(posedge clk) begin
        if (!rstn) begin
            busy_q <= 1'b0;
            conv_cnt_q <= 16'h0000;
        end else if (start) begin
            busy_q <= 1'b1;
            conv_cnt_q <= 16'(CONV_CYCLES - 1);
        end else if (done) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            conv_cnt_q <= dec16(conv_cnt_q);
        end
    end

    // Start pulse to the core
    always_ff @(posedge clk) begin
        if (!rstn) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= start;
        end
    end

    // Result register updates only at the end of a conversion
    always_ff @(posedge clk) begin
        if (!rstn) begin
            result_q <= '0;
        end else if (done) begin
            result_q <= conv_data;
        end
    end

    // Channel steps in continuous mode, where power-down also returns it to zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            chan_q <= '0;
        end else if (sync2_q.power_down_req && sync2_q.continuous_convert) begin
            chan_q <= '0;
        end else if (done && sync2_q.continuous_convert) begin
            chan_q <= chan_q + 1'b1;
        end
    end

    // Tracking resumes at the end of conversion; time the advised spacing
    always_ff @(posedge clk) begin
        if (!rstn) begin
            acq_cnt_q <= 16'(ACQ_CYC);
        end else if (busy_q) begin
            acq_cnt_q <= 16'(ACQ_CYC - CONV_CYCLES);
        end else begin
            acq_cnt_q <= dec16(acq_cnt_q);
        end
    end

    // Internal data clock: delay, then 12 pulses of previous result
    always_ff @(posedge clk) begin
        if (!rstn) begin
            seq_q <= ACC_IDLE;
            seq_cnt_q <= 5'h00;
            bit_cnt_q <= 4'h0;
            shreg_q <= '0;
            sclk_q <= 1'b0;
            sout_q <= 1'b0;
            tag_cap_q <= 1'b0;
        end else begin
            case (seq_q)
                ACC_IDLE: begin
                    // Both plain and continuous starts send the n-1 result
                    if (start && int_mode) begin
                        shreg_q <= result_q;
                        sout_q <= result_q[RES_W-1];
                        seq_cnt_q <= 5'(DCLK_DELAY_CYC - 1);
                        seq_q <= ACC_DELAY;
                    end
                end
                ACC_DELAY: begin
                    if (seq_cnt_q == 5'h00) begin
                        sclk_q <= 1'b1;
                        bit_cnt_q <= 4'h0;
                        seq_cnt_q <= 5'(DCLK_HI_CYC - 1);
                        seq_q <= ACC_HI;
                    end else begin
                        seq_cnt_q <= seq_cnt_q - 5'h01;
                    end
                end
                ACC_HI: begin
                    // Tag is caught during the first pulse
                    if (bit_cnt_q == 4'h0) begin
                        tag_cap_q <= sync2_q.tag;
                    end
                    if (seq_cnt_q == 5'h00) begin
                        sclk_q <= 1'b0;
                        seq_cnt_q <= 5'(DCLK_LO_CYC - 1);
                        seq_q <= ACC_LO;
                    end else begin
                        seq_cnt_q <= seq_cnt_q - 5'h01;
                    end
                end
                ACC_LO: begin
                    if (seq_cnt_q != 5'h00) begin
                        seq_cnt_q <= seq_cnt_q - 5'h01;
                    end else if (bit_cnt_q == 4'(NUM_PULSES - 1)) begin
                        sout_q <= tag_cap_q;
                        seq_q <= ACC_DONE;
                    end else begin
                        // Data changes on the same edge that raises the clock
                        shreg_q <= {shreg_q[RES_W-2:0], 1'b0};
                        sout_q <= shreg_q[RES_W-2];
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        sclk_q <= 1'b1;
                        seq_cnt_q <= 5'(DCLK_HI_CYC - 1);
                        seq_q <= ACC_HI;
                    end
                end
                ACC_DONE: begin
                    // Clock stays low until busy ends
                    if (!busy_q) begin
                        seq_q <= ACC_IDLE;
                    end
                end
                default: begin
                    seq_q <= ACC_IDLE;
                    sclk_q <= 1'b0;
                end
            endcase
        end
    end

    // Events for the external clock domain travel as toggles
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_state_q <= 1'b0;
            load_tgl_q <= 1'b0;
            frame_tgl_q <= 1'b0;
        end else begin
            rd_state_q <= rd_state;
            if (done) begin
                load_tgl_q <= !load_tgl_q;
            end
            if (ext_mode && rd_state && !rd_state_q) begin
                frame_tgl_q <= !frame_tgl_q;
            end
        end
    end

    // Shift chain on the external data clock; result_q is stable long before use
    acc_link_shift #(
        .WIDTH(RES_W)
    ) u_link (
        .link_clk(serial_clock_in),
        .rstn(rstn),
        .load_tgl(load_tgl_q),
        .frame_tgl(frame_tgl_q),
        .word(result_q),
        .tag(ctl_pins.tag),
        .shift_out(link_sout),
        .frame_out(link_frame)
    );

    // Parallel byte and enable, registered; follows result_q so it turns over one cycle after busy rise
    always_ff @(posedge clk) begin
        if (!rstn) begin
            par_q <= '0;
            par_en_q <= 1'b0;
        end else begin
            par_q <= sync2_q.byte_sel ? {result_q[3:0], LSB_PAD} : result_q[RES_W-1:4];
            par_en_q <= par_mode && rd_state;
        end
    end

    // Pin roles depend on parallel or serial mode
    always_comb begin
        bus.dout = '0;
        bus.oe = '0;
        if (par_mode) begin
            bus.dout = par_q;
            bus.oe = {BUS_W{par_en_q}};
        end else begin
            // Upper three float, mode select and tag are inputs
            bus.dout[PIN_FRAME] = ext_mode && link_frame;
            bus.oe[PIN_FRAME] = 1'b1;
            bus.dout[PIN_SCLK] = sclk_q;
            bus.oe[PIN_SCLK] = int_mode;
            bus.dout[PIN_SOUT] = ext_mode ? link_sout : sout_q;
            bus.oe[PIN_SOUT] = ext_mode ? rd_state_q : busy_q;
        end
    end

    assign busy_n = !busy_q;
    assign sample_hold = busy_q;
    assign acq_ready = (acq_cnt_q == 16'h0000) && !busy_q;
    assign chan_addr = chan_q;
    assign chan_addr_oe = sync2_q.continuous_convert;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    int unsigned pulse_cnt_q; // Rising edges of the internal clock this conversion
    always_ff @(posedge clk) begin
        if (!rstn || start) begin
            pulse_cnt_q <= 0;
        end else if (sclk_q && !$past(sclk_q)) begin
            pulse_cnt_q <= pulse_cnt_q + 1;
        end
    end

    a_busy_falls: assert property (start |=> !busy_n ##1 (!busy_n)[*8])
        else $error("busy did not fall and stay low after start");
    a_busy_length: assert property ($fell(busy_n) |-> conv_cnt_q == 16'(CONV_CYCLES - 1))
        else $error("conversion count wrong at busy fall");
    a_ignore_busy: assert property (busy_q && conv_cnt_q > 16'h0001 |=> conv_cnt_q == $past(conv_cnt_q) - 16'h0001)
        else $error("conversion restarted while busy");
    a_result_load: assert property ($rose(busy_n) |-> result_q == $past(conv_data))
        else $error("result not loaded at busy rise");
    a_par_float: assert property (par_mode && !rd_state ##1 par_mode |-> bus.oe == '0)
        else $error("parallel bus driven outside read");
    a_par_lsb: assert property (par_mode && rd_state && sync2_q.byte_sel |=> bus.dout[3:0] == LSB_PAD)
        else $error("low nibble not low with byte select high");
    a_int_pulses: assert property (seq_q == ACC_DONE && $past(seq_q) == ACC_LO |-> pulse_cnt_q == NUM_PULSES)
        else $error("internal clock pulse count wrong");
    a_int_clk_low: assert property (seq_q == ACC_DONE |-> !sclk_q && sout_q == tag_cap_q)
        else $error("clock not low or output not tag after last pulse");
    a_pd_inhibit: assert property (sync2_q.power_down_req && !busy_q |=> !busy_q)
        else $error("conversion started during power-down");
    a_msb_first: assert property (start && int_mode |=> sout_q == result_q[RES_W-1])
        else $error("serial output did not start with msb");
    a_chan_zero: assert property (sync2_q.power_down_req && sync2_q.continuous_convert |=> chan_q == '0)
        else $error("channel not reset in power-down");

    c_int_serial: cover property (start && int_mode ##[1:200] seq_q == ACC_DONE);
    c_par_read: cover property (par_mode && $rose(busy_n) ##[1:50] par_en_q);
    c_continuous: cover property (sync2_q.continuous_convert && done ##[1:5] start);
    c_ext_frame: cover property (ext_mode && rd_state && !rd_state_q);
endmodule

//--- verilog/acc_link_shift.sv
// External data clock shift chain, clocked by the link's own clock.
// Assumes load and frame requests arrive as toggles and word is held stable.
`timescale 1ns/1ps
module acc_link_shift import acc_pkg::*; #(
    parameter int WIDTH = RES_W
) (
    input wire logic link_clk,
    input wire logic rstn,
    input wire logic load_tgl,
    input wire logic frame_tgl,
    input wire logic [WIDTH-1:0] word,
    input wire logic tag,
    output logic shift_out,
    output logic frame_out
);
    if (WIDTH < 2) begin : g_chk
        $error("acc_link_shift needs WIDTH of at least 2");
    end

    logic rst1_q, rst2_q; // Reset brought into the link domain
    logic ld1_q, ld2_q, ld3_q; // Load toggle synchroniser and edge stage
    logic fr1_q, fr2_q, fr3_q; // Frame toggle synchroniser and edge stage
    logic [WIDTH-1:0] sreg_q; // Shift chain
    logic load_ev, frame_ev;

    // Reset synchroniser; the link clock may stop, so reset lands on its next edges
    always_ff @(posedge link_clk) begin
        rst1_q <= rstn;
        rst2_q <= rst1_q;
    end

    // Toggle synchronisers; only the second and edge stages feed logic
    always_ff @(posedge link_clk) begin
        if (!rst2_q) begin
            {ld1_q, ld2_q, ld3_q} <= 3'h0;
            {fr1_q, fr2_q, fr3_q} <= 3'h0;
        end else begin
            {ld1_q, ld2_q, ld3_q} <= {load_tgl, ld1_q, ld2_q};
            {fr1_q, fr2_q, fr3_q} <= {frame_tgl, fr1_q, fr2_q};
        end
    end

    assign load_ev = ld2_q ^ ld3_q;
    assign frame_ev = fr2_q ^ fr3_q;

    // Chain: load on request, else shift in tag so output is tag of 12 clocks back
    always_ff @(posedge link_clk) begin
        if (!rst2_q) begin
            sreg_q <= '0;
        end else if (load_ev || frame_ev) begin
            sreg_q <= word;
        end else begin
            sreg_q <= {sreg_q[WIDTH-2:0], tag};
        end
    end

    // Frame pulse: high for one link clock when a read begins
    always_ff @(posedge link_clk) begin
        if (!rst2_q) begin
            frame_out <= 1'b0;
        end else begin
            frame_out <= frame_ev;
        end
    end

    // Most significant bit leads
    assign shift_out = sreg_q[WIDTH-1];
endmodule

//--- verilog/acc_pkg.sv
// Shared constants and types for the converter start and read control.
// Assumes a 10 MHz system clock; all cycle counts derive from it.
package acc_pkg;
    // Widths
    localparam int RES_W = 12;
    localparam int BUS_W = 8;
    localparam int CHAN_W = 2;
    localparam int NUM_PULSES = 12;
    // System clock period
    localparam int CLK_NS = 100;
    // Least convert pulse, rounded up to whole cycles
    localparam int CMD_MIN_NS = 40;
    localparam int CMD_MIN_CYC = (CMD_MIN_NS + CLK_NS - 1) / CLK_NS;
    // Conversion time, typical
    localparam int CONV_NS = 15000;
    localparam int CONV_CYC = CONV_NS / CLK_NS;
    // Advised spacing of convert commands
    localparam int ACQ_US = 25;
    localparam int ACQ_CYC = ACQ_US * 1000 / CLK_NS;
    // Start of conversion to first data clock
    localparam int DCLK_DELAY_NS = 1400;
    localparam int DCLK_DELAY_CYC = DCLK_DELAY_NS / CLK_NS;
    // Internal data clock period and its halves
    localparam int DCLK_PERIOD_NS = 1100;
    localparam int DCLK_PERIOD_CYC = DCLK_PERIOD_NS / CLK_NS;
    localparam int DCLK_HI_CYC = DCLK_PERIOD_CYC / 2;
    localparam int DCLK_LO_CYC = DCLK_PERIOD_CYC - DCLK_HI_CYC;
    // Serial mode pin positions on the 8-bit bus
    localparam int PIN_EXTSEL = 4;
    localparam int PIN_FRAME = 3;
    localparam int PIN_SCLK = 2;
    localparam int PIN_SOUT = 1;
    localparam int PIN_TAG = 0;
    // Low nibble driven with the least significant byte
    localparam logic [3:0] LSB_PAD = 4'h0;

    // Internal data clock sequencer, one-hot
    typedef enum logic [4:0] {
        ACC_IDLE  = 5'h01,
        ACC_DELAY = 5'h02,
        ACC_HI    = 5'h04,
        ACC_LO    = 5'h08,
        ACC_DONE  = 5'h10
    } acc_seq_t;

    // Control pins, all asynchronous to clk
    typedef struct packed {
        logic cs_n;
        logic rd_conv;
        logic byte_sel;
        logic parallel_serial_sel;
        logic external_clock_sel;
        logic continuous_convert;
        logic power_down_req;
        logic tag;
    } acc_ctl_t;

    // Value of the control pins while idle
    localparam acc_ctl_t CTL_IDLE = '{cs_n: 1'b1, rd_conv: 1'b1, default: 1'b0};

    // Data bus pins: drive value and enable
    typedef struct packed {
        logic [BUS_W-1:0] dout;
        logic [BUS_W-1:0] oe;
    } acc_bus_t;
endpackage
